// ---- verilog/cga_cfg.svh ----
// Constants for the character generator address block
`ifndef CGA_CFG_SVH
`define CGA_CFG_SVH
// APB register byte offsets
`define CGA_OFF_CTRL      12'h000
`define CGA_OFF_BASE      12'h004
`define CGA_OFF_CELL      12'h008
`define CGA_OFF_FETCH     12'h00c
`define CGA_OFF_ADDR      12'h010
`define CGA_OFF_STATUS    12'h014
// Control field positions
`define CGA_CTRL_ROMSRC   0
`define CGA_CTRL_FOLD     1
`define CGA_CTRL_TALL     2
// Reset values
`define CGA_CTRL_RST      3'h0
`define CGA_BASE_RST      16'h0000
`define CGA_CELL_RST      4'h7
`define CGA_WIDTH_RST     16'h013f
// Code ranges served by user character RAM, and the code bit cleared by fold
`define CGA_USR1_LO       8'h80
`define CGA_USR1_HI       8'h9f
`define CGA_USR2_LO       8'he0
`define CGA_FOLD_BIT      6
// Address layout
`define CGA_SHORT_SHIFT   3
`define CGA_TALL_SHIFT    4
`define CGA_SHORT_ROW_W   3
`define CGA_TALL_ROW_W    4
`define CGA_BYTE_BITS     8
`endif

// ---- verilog/cga_pkg.sv ----
// Types shared by the character generator address block
`default_nettype none
package cga_pkg;
  // One font fetch request
  typedef struct packed {
    logic [7:0] code;
    logic [3:0] row;
    logic [3:0] pixel;
    logic       last_cell;
  } cga_req_s;
  // One resolved fetch
  typedef struct packed {
    logic [15:0] addr;
    logic        user_ram;
    logic        blank;
  } cga_fetch_s;
  typedef enum logic [1:0] {
    CGA_IDLE,
    CGA_SETUP,
    CGA_ACCESS
  } cga_apb_e;
endpackage
`default_nettype wire

// ---- verilog/cga_addr_calc.sv ----
// Font address sum for one character row
`timescale 1ns/100ps
`default_nettype none
`include "cga_cfg.svh"
module cga_addr_calc
  import cga_pkg::*;
(
  // Settings
  input  wire logic [15:0] base_i,
  input  wire logic        tall_i,
  input  wire logic        fold_i,
  input  wire logic        rom_src_i,
  // Request
  input  wire logic [7:0]  code_i,
  input  wire logic [3:0]  row_i,
  // Result
  output logic [15:0]      addr_o,
  output logic             user_ram_o
);
  // User character RAM code ranges
  function automatic logic is_user(input logic [7:0] c);
    is_user = (c >= `CGA_USR1_LO && c <= `CGA_USR1_HI) ||
              (c >= `CGA_USR2_LO);
  endfunction

  logic [7:0]  code_eff;
  logic [15:0] code_term;
  logic [15:0] row_term;

  // Map code and fold bit 6 for the second user area
  always_comb begin
    code_eff = code_i;
    if (fold_i && code_i >= `CGA_USR2_LO) begin
      code_eff[`CGA_FOLD_BIT] = 1'b0; // [RULE_03]
    end
    user_ram_o = !rom_src_i || is_user(code_i); // [RULE_05] [RULE_06]
    if (tall_i) begin
      code_term = {4'h0, code_eff, 4'h0}; // [RULE_01] [RULE_13]
      row_term  = {12'h000, row_i}; // [RULE_02]
    end else begin
      code_term = {5'h00, code_eff, 3'h0}; // [RULE_01]
      row_term  = {13'h0000, row_i[2:0]}; // [RULE_02]
    end
    addr_o = 16'(base_i + code_term + row_term); // [RULE_14]
  end
endmodule
`default_nettype wire

// ---- verilog/cga_apb_regs.sv ----
// APB slave register file for the character generator block
`timescale 1ns/100ps
`default_nettype none
`include "cga_cfg.svh"
module cga_apb_regs
  import cga_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  // APB
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Settings out
  output logic [2:0]       ctrl_o,
  output logic [15:0]      base_o,
  output logic [3:0]       cell_w_o,
  output logic [15:0]      width_o,
  output logic             fetch_go_o,
  output logic [16:0]      fetch_req_o,
  // State in
  input  wire cga_fetch_s  result_i,
  input  wire logic        busy_i
);
  logic acc;
  logic wr;
  assign acc = psel_i && penable_i;
  assign wr  = acc && pwrite_i;

  // Writable settings
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_o   <= `CGA_CTRL_RST;
      base_o   <= `CGA_BASE_RST;
      cell_w_o <= `CGA_CELL_RST;
      width_o  <= `CGA_WIDTH_RST;
    end else if (wr) begin
      case (paddr_i)
        `CGA_OFF_CTRL: ctrl_o <= pwdata_i[2:0];
        `CGA_OFF_BASE: base_o <= pwdata_i[15:0];
        `CGA_OFF_CELL: begin
          cell_w_o <= pwdata_i[3:0];
          width_o  <= pwdata_i[31:16];
        end
        default: ;
      endcase
    end
  end

  // Fetch launch pulse
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fetch_go_o  <= 1'b0;
      fetch_req_o <= 17'h00000;
    end else begin
      fetch_go_o <= wr && paddr_i == `CGA_OFF_FETCH;
      if (wr && paddr_i == `CGA_OFF_FETCH) begin
        fetch_req_o <= pwdata_i[16:0];
      end
    end
  end

  // Read data and answer, zero wait
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prdata_o  <= 32'h00000000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i && !penable_i;
      pslverr_o <= 1'b0;
      prdata_o  <= 32'h00000000;
      if (psel_i && !penable_i) begin
        case (paddr_i)
          `CGA_OFF_CTRL:   prdata_o <= {29'h0, ctrl_o};
          `CGA_OFF_BASE:   prdata_o <= {16'h0, base_o};
          `CGA_OFF_CELL:   prdata_o <= {width_o, 12'h0, cell_w_o};
          `CGA_OFF_FETCH:  prdata_o <= {15'h0, fetch_req_o};
          `CGA_OFF_ADDR:   prdata_o <= {16'h0, result_i.addr};
          `CGA_OFF_STATUS: prdata_o <= {29'h0, busy_i,
                                        result_i.user_ram,
                                        result_i.blank};
          default:         pslverr_o <= 1'b1;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ---- verilog/cga_top.sv ----
// Character generator fetch address block with APB registers
//
// Overview of operation
// RULE_01 - Fetch address is base plus shifted code plus row index.
// RULE_02 - Row index is the binary pixel row, 0-7 short, 0-15 tall.
// RULE_03 - Fold option clears code bit 6 in the second user area.
// RULE_04 - Host writing fonts with fold clears bit 6 itself.
// RULE_05 - Codes 80h-9Fh and E0h-FFh come from user character RAM.
// RULE_06 - Without the built-in ROM every code uses user RAM.
// RULE_07 - Size fields hold value minus one; logic adds one.
// RULE_08 - Host keeps cell width at least panel width over chars.
// RULE_09 - Host sets bytes per line from width/8 rounded up.
// RULE_10 - Host sets total line period at least bytes plus four.
// RULE_11 - Host picks oscillator above the line and frame bound.
// RULE_12 - Leftover pixels past the last whole cell are blanked.
// RULE_13 - Tall select picks 8-row or 16-row cell layout.
// RULE_14 - Address sum is 16 bits, carry discarded.
`timescale 1ns/100ps
`default_nettype none
`include "cga_cfg.svh"
module cga_top
  import cga_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        ARST_N_I,
  // APB slave
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [11:0] PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic [31:0]      PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  // Pixel stream fetch port
  input  wire logic        FETCH_VALID_I,
  input  wire cga_req_s    FETCH_REQ_I,
  output logic             FETCH_VALID_O,
  output logic [15:0]      FETCH_ADDR_O,
  output logic             FETCH_USER_RAM_O,
  output logic             FETCH_BLANK_O
);
  logic [2:0]  ctrl;
  logic [15:0] base;
  logic [3:0]  cell_w;
  logic [15:0] width;
  logic        sw_go;
  logic [16:0] sw_req;
  logic [15:0] addr;
  logic        user_ram;
  logic [7:0]  sel_code;
  logic [3:0]  sel_row;
  logic        sel_blank;
  logic [4:0]  cell_eff;
  logic [15:0] width_eff;
  cga_fetch_s  result;
  logic        busy;

  // Register file
  cga_apb_regs u_regs (
    .clk_i      (CLK_I),
    .arst_n_i   (ARST_N_I),
    .psel_i     (PSEL_I),
    .penable_i  (PENABLE_I),
    .pwrite_i   (PWRITE_I),
    .paddr_i    (PADDR_I),
    .pwdata_i   (PWDATA_I),
    .prdata_o   (PRDATA_O),
    .pready_o   (PREADY_O),
    .pslverr_o  (PSLVERR_O),
    .ctrl_o     (ctrl),
    .base_o     (base),
    .cell_w_o   (cell_w),
    .width_o    (width),
    .fetch_go_o (sw_go),
    .fetch_req_o(sw_req),
    .result_i   (result),
    .busy_i     (busy)
  );

  // Effective sizes are field plus one
  assign cell_eff  = 5'({1'b0, cell_w} + 5'h01); // [RULE_07]
  assign width_eff = 16'(width + 16'h0001); // [RULE_07]

  // Stream request wins over software probe
  always_comb begin
    if (FETCH_VALID_I) begin
      sel_code  = FETCH_REQ_I.code;
      sel_row   = FETCH_REQ_I.row;
      // Partial last cell pixels beyond the panel edge
      sel_blank = FETCH_REQ_I.last_cell &&
                  ({1'b0, FETCH_REQ_I.pixel} >= cell_eff); // [RULE_12]
    end else begin
      sel_code  = sw_req[7:0];
      sel_row   = sw_req[11:8];
      sel_blank = sw_req[16] &&
                  ({1'b0, sw_req[15:12]} >= cell_eff); // [RULE_12]
    end
  end

  // Address arithmetic
  cga_addr_calc u_calc (
    .base_i    (base),
    .tall_i    (ctrl[`CGA_CTRL_TALL]), // [RULE_13]
    .fold_i    (ctrl[`CGA_CTRL_FOLD]),
    .rom_src_i (ctrl[`CGA_CTRL_ROMSRC]),
    .code_i    (sel_code),
    .row_i     (sel_row),
    .addr_o    (addr),
    .user_ram_o(user_ram)
  );

  // Registered fetch outputs
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      FETCH_VALID_O    <= 1'b0;
      FETCH_ADDR_O     <= 16'h0000;
      FETCH_USER_RAM_O <= 1'b0;
      FETCH_BLANK_O    <= 1'b0;
    end else begin
      FETCH_VALID_O    <= FETCH_VALID_I || sw_go;
      FETCH_ADDR_O     <= addr;
      FETCH_USER_RAM_O <= user_ram;
      FETCH_BLANK_O    <= sel_blank; // [RULE_12]
    end
  end

  // Last result seen by software
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      result <= '0;
      busy   <= 1'b0;
    end else begin
      busy <= FETCH_VALID_I;
      if (FETCH_VALID_I || sw_go) begin
        result.addr     <= addr;
        result.user_ram <= user_ram;
        result.blank    <= sel_blank;
      end
    end
  end

  // Width kept for software, unused by fetch path
  logic unused_width;
  assign unused_width = ^width_eff;
endmodule
`default_nettype wire

// ---- test/cga_top_assertions.sv ----
// Port checker for the character generator fetch block
`timescale 1ns/100ps
`default_nettype none
module cga_top_assertions
  import cga_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        ARST_N_I,
  // APB
  input wire logic        PSEL_I,
  input wire logic        PENABLE_I,
  input wire logic        PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  // Fetch port
  input wire logic        FETCH_VALID_I,
  input wire cga_req_s    FETCH_REQ_I,
  input wire logic        FETCH_VALID_O,
  input wire logic [15:0] FETCH_ADDR_O,
  input wire logic        FETCH_USER_RAM_O,
  input wire logic        FETCH_BLANK_O
);
  logic [2:0]  ctl;
  logic [15:0] base;
  logic [3:0]  cw;
  logic [7:0]  cf;
  logic [16:0] sum;
  logic [15:0] ea;
  logic        ec, et, ef, er, eu, eb;
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // Shadow of settings written over APB
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl  <= 3'h0;
      base <= 16'h0000;
      cw   <= 4'h7;
    end else if (PSEL_I && PENABLE_I && PWRITE_I) begin
      if (PADDR_I == 12'h000) ctl <= PWDATA_I[2:0];
      if (PADDR_I == 12'h004) base <= PWDATA_I[15:0];
      if (PADDR_I == 12'h008) cw <= PWDATA_I[3:0];
    end
  end
  // Expected address, carry kept in bit 16
  assign cf = (ctl[1] && FETCH_REQ_I.code[7:5] == 3'h7) ?
              FETCH_REQ_I.code & 8'hbf : FETCH_REQ_I.code;
  assign sum = ctl[2] ?
    {1'b0, base} + {5'h00, cf, 4'h0} + {13'h0000, FETCH_REQ_I.row} :
    {1'b0, base} + {6'h00, cf, 3'h0} + {14'h0000, FETCH_REQ_I.row[2:0]};
  // Note expectation with each stream request
  always_ff @(posedge CLK_I) begin
    if (FETCH_VALID_I) begin
      ea <= sum[15:0];
      ec <= sum[16];
      et <= ctl[2];
      ef <= ctl[1] && FETCH_REQ_I.code[7:5] == 3'h7;
      er <= ctl[0];
      eu <= FETCH_REQ_I.code[7:5] == 3'h4 || FETCH_REQ_I.code[7:5] == 3'h7;
      eb <= FETCH_REQ_I.last_cell && FETCH_REQ_I.pixel > cw;
    end
  end
  property p_lat; FETCH_VALID_I |=> FETCH_VALID_O; endproperty
  a_lat: assert property (p_lat) else $error("fetch late");
  property p_sh; $past(FETCH_VALID_I) && !et |-> FETCH_ADDR_O == ea; endproperty
  a_sh: assert property (p_sh) else $error("short addr");
  property p_tl; FETCH_VALID_I && ctl[2] ##1 1'b1 |-> FETCH_ADDR_O == ea; endproperty
  a_tl: assert property (p_tl) else $error("tall addr");
  property p_fd; $past(FETCH_VALID_I) && ef |-> FETCH_ADDR_O == ea; endproperty
  a_fd: assert property (p_fd) else $error("fold addr");
  property p_wr; FETCH_VALID_O && ec && $past(FETCH_VALID_I) |-> FETCH_ADDR_O == ea; endproperty
  a_wr: assert property (p_wr) else $error("wrap addr");
  property p_rm; $past(FETCH_VALID_I) && er |-> FETCH_USER_RAM_O == eu; endproperty
  a_rm: assert property (p_rm) else $error("code range");
  property p_al; FETCH_VALID_I && !ctl[0] |=> FETCH_USER_RAM_O; endproperty
  a_al: assert property (p_al) else $error("user ram");
  property p_bl; $past(FETCH_VALID_I) |-> FETCH_BLANK_O == eb; endproperty
  a_bl: assert property (p_bl) else $error("blank");
  // Main scenarios reached
  c_tall: cover property (FETCH_VALID_O && et);
  c_fold: cover property ($past(FETCH_VALID_I) && ef && ec);
  c_blank: cover property (FETCH_VALID_O && FETCH_BLANK_O);
endmodule
bind cga_top cga_top_assertions u_chk (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I),
  .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I),
  .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I), .FETCH_VALID_I(FETCH_VALID_I),
  .FETCH_REQ_I(FETCH_REQ_I), .FETCH_VALID_O(FETCH_VALID_O),
  .FETCH_ADDR_O(FETCH_ADDR_O), .FETCH_USER_RAM_O(FETCH_USER_RAM_O),
  .FETCH_BLANK_O(FETCH_BLANK_O));
`default_nettype wire

// ---- test/cga_font_mem.sv ----
// Display memory model answering font fetches
`timescale 1ns/100ps
`default_nettype none
module cga_font_mem (
  // Clock and fetch
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  // Font row
  output logic [7:0]       pix_o
);
  // Pattern from address; idle cycles flip the last value
  always_ff @(posedge clk_i) begin
    pix_o <= rd_i ? addr_i[7:0] ^ addr_i[15:8] : ~pix_o;
  end
endmodule
`default_nettype wire

// ---- test/tb_cga_top.sv ----
// Self-checking bench for the character generator fetch block
`timescale 1ns/100ps
`default_nettype none
module tb_cga_top
  import cga_pkg::*;
  ;
  logic        CLK_I, ARST_N_I, PSEL_I, PENABLE_I, PWRITE_I, FETCH_VALID_I;
  logic [11:0] PADDR_I;
  logic [31:0] PWDATA_I, PRDATA_O, rd;
  logic        PREADY_O, PSLVERR_O, FETCH_VALID_O, FETCH_USER_RAM_O;
  logic        FETCH_BLANK_O, err;
  logic [15:0] FETCH_ADDR_O, t_base;
  logic [7:0]  pix;
  logic [7:0]  tbl [8] = '{8'h00, 8'h7f, 8'h80, 8'h9f,
                           8'ha0, 8'hdf, 8'he0, 8'hff};
  logic [2:0]  t_ctl;
  logic [3:0]  t_cw;
  cga_req_s    FETCH_REQ_I, rq;
  cga_fetch_s  q[$];
  cga_fetch_s  sf;
  cga_fetch_s  pe;
  logic [7:0]  hc;
  logic [15:0] ha;
  int          seed = 48585;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          r;
  cga_top u_dut (.CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
    .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
    .PWDATA_I(PWDATA_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
    .PSLVERR_O(PSLVERR_O), .FETCH_VALID_I(FETCH_VALID_I),
    .FETCH_REQ_I(FETCH_REQ_I), .FETCH_VALID_O(FETCH_VALID_O),
    .FETCH_ADDR_O(FETCH_ADDR_O), .FETCH_USER_RAM_O(FETCH_USER_RAM_O),
    .FETCH_BLANK_O(FETCH_BLANK_O));
  cga_font_mem u_mem (.clk_i(CLK_I), .rd_i(FETCH_VALID_O),
    .addr_i(FETCH_ADDR_O), .pix_o(pix));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("Comparisons %0d, errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge CLK_I);
    PSEL_I   <= 1'b1;
    PWRITE_I <= w;
    PADDR_I  <= a;
    PWDATA_I <= d;
    @(posedge CLK_I);
    PENABLE_I <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
    end while (PREADY_O !== 1'b1 && n < 16);
    if (PREADY_O !== 1'b1) begin
      num_errors++;
      print_verdict();
    end
    rd = PRDATA_O;
    err = PSLVERR_O;
    PSEL_I    <= 1'b0;
    PENABLE_I <= 1'b0;
  endtask
  // Expected answer from the current settings
  function automatic cga_fetch_s expf(cga_req_s x);
    logic [7:0] c;
    cga_fetch_s f;
    c = (t_ctl[1] && x.code >= 8'he0) ? x.code & 8'hbf : x.code;
    f.addr = t_ctl[2] ? t_base + {4'h0, c, 4'h0} + {12'h0, x.row} :
                        t_base + {5'h0, c, 3'h0} + {13'h0, x.row[2:0]};
    f.user_ram = !t_ctl[0] || x.code[7:5] == 3'h4 || x.code >= 8'he0;
    f.blank = x.last_cell && x.pixel > t_cw;
    return f;
  endfunction
  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end
  // Compare each answer against the oldest note
  always @(negedge CLK_I) begin
    if (FETCH_VALID_O === 1'b1) begin
      sf = {FETCH_ADDR_O, FETCH_USER_RAM_O, FETCH_BLANK_O};
      if (q.size() == 0) check(32'h1, 32'h0);
      else check({14'h0, sf}, {14'h0, q.pop_front()});
    end
  end
  // Reset, register checks, fetch bursts in every mode
  initial begin
    {ARST_N_I, PSEL_I, PENABLE_I, PWRITE_I, FETCH_VALID_I} = '0;
    PADDR_I = '0;
    PWDATA_I = '0;
    FETCH_REQ_I = '0;
    repeat (16) @(posedge CLK_I);
    ARST_N_I <= 1'b1;
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h013f0007);
    apb(1'b0, 12'h01c, 32'h0);
    check({31'h0, err}, 32'h1);
    for (int m = 0; m < 8; m++) begin
      t_ctl = m[2:0];
      t_base = (m == 5) ? 16'hff00 : 16'($random(seed));
      t_cw = 4'($random(seed));
      apb(1'b1, 12'h000, {29'h0, t_ctl});
      apb(1'b1, 12'h004, {16'h0, t_base});
      // Cell and panel widths as the host programs them
      apb(1'b1, 12'h008, {16'h013f, 12'h0, t_cw});
      apb(1'b0, 12'h004, 32'h0);
      check(rd, {16'h0, t_base});
      for (int i = 0; i < 48; i++) begin
        @(posedge CLK_I);
        r = $random(seed);
        rq = r[16:0];
        if (i < 8) rq.code = tbl[i];
        if (!t_ctl[2]) rq.row[3] = 1'b0;
        FETCH_VALID_I <= (i < 8) || r[31];
        FETCH_REQ_I <= rq;
        if ((i < 8) || r[31]) q.push_back(expf(rq));
      end
      @(posedge CLK_I);
      FETCH_VALID_I <= 1'b0;
      repeat (3) @(posedge CLK_I);
      // Software probe with a second-area user code
      r = $random(seed);
      rq = r[16:0];
      rq.code[7:5] = 3'h7;
      if (!t_ctl[2]) rq.row[3] = 1'b0;
      pe = expf(rq);
      q.push_back(pe);
      apb(1'b1, 12'h00c, {15'h0, rq.last_cell, rq.pixel, rq.row, rq.code});
      // Host font address: plain layout, bit 6 dropped when folding
      hc = rq.code;
      if (t_ctl[1]) hc[6] = 1'b0;
      ha = t_ctl[2] ? 16'(t_base + {hc, 4'h0} + rq.row) :
                      16'(t_base + {hc, 3'h0} + rq.row[2:0]);
      apb(1'b0, 12'h010, 32'h0);
      check(rd, {16'h0, ha});
      apb(1'b0, 12'h014, 32'h0);
      check(rd, {29'h0, 1'b0, pe.user_ram, pe.blank});
    end
    check(32'(q.size()), 32'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
